/* File: rtl/rotate_right_exec_unit.sv */
// rotate-right execution datapath, one instruction per four quarter phases
`timescale 1ns/1ns
`default_nettype none
module rotate_right_exec_unit
  import rotate_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_valid,
  input wire logic [rotate_pkg::insn_w-1:0] insn,
  input wire logic [rotate_pkg::data_w-1:0] reg_rdata,
  input wire logic carry_in,
  output logic [1:0] qphase,
  output logic reg_re,
  output logic [rotate_pkg::addr_w-1:0] reg_addr,
  output logic reg_we,
  output logic [rotate_pkg::data_w-1:0] reg_wdata,
  output logic acc_we,
  output logic [rotate_pkg::data_w-1:0] acc_wdata,
  output logic carry_we,
  output logic carry_out,
  output logic busy
);
  import rotate_pkg::*;

  rotate_if dif();
  rotate_decode u_dec (
    .insn(insn),
    .d(dif)
  );

  qphase_e phase;
  logic op_carry;
  logic op_wrap;
  logic op_dest;
  logic [7:0] operand;
  logic [7:0] result;
  logic new_carry;
  logic [7:0] next_result;
  logic next_carry;

  // phase counter idles in decode until a rotate instruction is offered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= q_decode;
    end else begin
      case (phase)
        q_decode: begin
          if (insn_valid && (dif.is_carry || dif.is_wrap)) begin
            phase <= q_read;
          end
        end
        q_read: phase <= q_process;
        q_process: phase <= q_write;
        q_write: phase <= q_decode;
        default: phase <= q_decode;
      endcase
    end
  end

  // latch decoded fields in Q1 so the instruction word may change afterwards
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_carry <= 1'b0;
      op_wrap <= 1'b0;
      op_dest <= dest_accumulator;
      reg_addr <= 8'h00;
    end else if (phase == q_decode && insn_valid && (dif.is_carry || dif.is_wrap)) begin
      op_carry <= dif.is_carry;
      op_wrap <= dif.is_wrap;
      op_dest <= dif.dest;
      reg_addr <= dif.addr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operand <= data_reset;
    end else if (phase == q_read) begin
      operand <= reg_rdata;
    end
  end

  always_comb begin
    next_result = result;
    next_carry = new_carry;
    if (op_carry) begin
      next_result = {carry_in, operand[7:1]};
      next_carry = operand[0];
    end else if (op_wrap) begin
      next_result = {operand[0], operand[7:1]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result <= data_reset;
      new_carry <= 1'b0;
    end else if (phase == q_process) begin
      result <= next_result;
      new_carry <= next_carry;
    end
  end

  // registered strobes: read in Q2, write in Q4
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_re <= 1'b0;
      reg_we <= 1'b0;
      acc_we <= 1'b0;
      carry_we <= 1'b0;
      reg_wdata <= data_reset;
      acc_wdata <= data_reset;
      carry_out <= 1'b0;
    end else begin
      reg_re <= phase == q_decode && insn_valid && (dif.is_carry || dif.is_wrap);
      reg_we <= phase == q_process && op_dest == dest_register;
      acc_we <= phase == q_process && op_dest == dest_accumulator;
      carry_we <= phase == q_process && op_carry;
      if (phase == q_process) begin
        reg_wdata <= next_result;
        acc_wdata <= next_result;
        carry_out <= next_carry;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qphase <= 2'h0;
      busy <= 1'b0;
    end else begin
      qphase <= next_phase_code(phase, insn_valid && (dif.is_carry || dif.is_wrap));
      busy <= (phase == q_decode) ? (insn_valid && (dif.is_carry || dif.is_wrap))
                                  : (phase != q_write);
    end
  end

  function automatic logic [1:0] next_phase_code(input qphase_e p, input logic go);
    case (p)
      q_decode: next_phase_code = go ? 2'h1 : 2'h0;
      q_read: next_phase_code = 2'h2;
      q_process: next_phase_code = 2'h3;
      default: next_phase_code = 2'h0;
    endcase
  endfunction

  sequence start_s;
    phase == q_decode && insn_valid && (dif.is_carry || dif.is_wrap);
  endsequence

  sequence write_s;
    (reg_we || acc_we);
  endsequence

  property one_cycle_p;
    @(posedge clk) disable iff (!resetn) start_s |-> ##3 write_s;
  endproperty

  one_cycle_a: assert property (one_cycle_p)
    else $error("rotate did not write in fourth phase");

  carry_math_a: assert property (@(posedge clk) disable iff (!resetn)
    phase == q_process && op_carry |=> reg_wdata == {$past(carry_in), $past(operand[7:1])}
      && carry_out == $past(operand[0]))
    else $error("carry rotate result wrong");

  wrap_math_a: assert property (@(posedge clk) disable iff (!resetn)
    phase == q_process && op_wrap |=> reg_wdata == {$past(operand[0]), $past(operand[7:1])})
    else $error("wrap rotate result wrong");

  wrap_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    phase == q_process && op_wrap |=> !carry_we)
    else $error("plain rotate touched carry");

  dest_reg_a: assert property (@(posedge clk) disable iff (!resetn)
    phase == q_process && op_dest |=> reg_we && !acc_we)
    else $error("register destination not honoured");

  dest_acc_a: assert property (@(posedge clk) disable iff (!resetn)
    phase == q_process && !op_dest |=> acc_we && !reg_we)
    else $error("accumulator destination not honoured");

  addr_take_a: assert property (@(posedge clk) disable iff (!resetn)
    start_s |=> reg_addr == $past(insn[7:0]) && reg_re)
    else $error("address not taken from low byte");

  // other opcodes must not disturb the address seen by the register file
  addr_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !(phase == q_decode && insn_valid && (dif.is_carry || dif.is_wrap)) |=> $stable(reg_addr))
    else $error("address changed without a rotate");

  carry_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
    carry_we |-> $past(phase == q_process && op_carry))
    else $error("spurious carry write");
endmodule
`default_nettype wire

/* File: rtl/rotate_pkg.sv */
// constants shared by the rotate execution unit
package rotate_pkg;
  localparam int unsigned clk_period_ns = 10;
  localparam int unsigned data_w = 8;
  localparam int unsigned insn_w = 16;
  localparam int unsigned addr_w = 8;
  // opcode field sits in the top seven bits, destination bit below it
  localparam int unsigned opcode_lsb = 9;
  localparam int unsigned opcode_w = 7;
  localparam int unsigned dest_bit = 8;
  localparam logic [6:0] opc_rotate_carry = 7'h0c;
  localparam logic [6:0] opc_rotate_wrap = 7'h10;
  localparam logic dest_accumulator = 1'b0;
  localparam logic dest_register = 1'b1;
  localparam logic [7:0] data_reset = 8'h00;
  typedef enum logic [1:0] {
    q_decode,
    q_read,
    q_process,
    q_write
  } qphase_e;
endpackage

/* File: rtl/rotate_if.sv */
// carrier for the decoded instruction between decoder and datapath
`timescale 1ns/1ns
`default_nettype none
interface rotate_if;
  logic is_carry;
  logic is_wrap;
  logic dest;
  logic [7:0] addr;
  modport dec (output is_carry, output is_wrap, output dest, output addr);
  modport exe (input is_carry, input is_wrap, input dest, input addr);
endinterface
`default_nettype wire

/* File: rtl/rotate_decode.sv */
// instruction field decoder for the two rotate instructions
`timescale 1ns/1ns
`default_nettype none
module rotate_decode
  import rotate_pkg::*;
(
  input wire logic [rotate_pkg::insn_w-1:0] insn,
  rotate_if.dec d
);
  assign d.is_carry = insn[insn_w-1 -: opcode_w] == opc_rotate_carry;
  assign d.is_wrap = insn[insn_w-1 -: opcode_w] == opc_rotate_wrap;
  assign d.dest = insn[dest_bit];
  assign d.addr = insn[addr_w-1:0];
endmodule
`default_nettype wire

/* File: bench/rotate_right_exec_unit_tb.sv */
// self-checking bench for the rotate-right execution unit
`timescale 1ns/1ns
`default_nettype none
module rotate_right_exec_unit_tb;
  import rotate_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic insn_valid = 1'b0;
  logic [insn_w-1:0] insn = 16'h0000;
  logic [data_w-1:0] reg_rdata = 8'h00;
  logic carry_in = 1'b0;
  logic [1:0] qphase;
  logic reg_re, reg_we, acc_we, carry_we, carry_out, busy;
  logic [7:0] reg_addr, reg_wdata, acc_wdata;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  rotate_right_exec_unit dut (.clk(clk), .resetn(resetn), .insn_valid(insn_valid),
    .insn(insn), .reg_rdata(reg_rdata), .carry_in(carry_in), .qphase(qphase),
    .reg_re(reg_re), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .carry_we(carry_we),
    .carry_out(carry_out), .busy(busy));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // the whole run needs about 35 cycles; anything far beyond is a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // called at a falling edge; returns at the falling edge of the idle cycle
  task automatic exec(input logic [6:0] opc, input logic dest, input logic [7:0] addr,
                      input logic [7:0] d, input logic cin);
    logic wrap;
    logic [7:0] res;
    wrap = (opc == opc_rotate_wrap);
    res = wrap ? {d[0], d[7:1]} : {cin, d[7:1]};
    insn_valid = 1'b1;
    insn = {opc, dest, addr};
    reg_rdata = d;
    carry_in = cin;
    @(negedge clk);
    insn_valid = 1'b0;
    chk("reg_re", 8'h01, 8'(reg_re));
    chk("reg_addr", addr, reg_addr);
    chk("qphase", 8'h01, 8'(qphase));
    chk("busy_q2", 8'h01, 8'(busy));
    @(negedge clk);
    // operand no longer valid, and a request while busy must be dropped
    reg_rdata = ~d;
    insn_valid = 1'b1;
    chk("reg_re_off", 8'h00, 8'(reg_re));
    chk("qphase_q3", 8'h02, 8'(qphase));
    chk("busy_q3", 8'h01, 8'(busy));
    @(negedge clk);
    insn_valid = 1'b0;
    carry_in = ~cin;
    chk("qphase_q4", 8'h03, 8'(qphase));
    chk("busy_q4", 8'h01, 8'(busy));
    chk("reg_we", 8'(dest), 8'(reg_we));
    chk("acc_we", 8'(!dest), 8'(acc_we));
    chk("reg_wdata", res, reg_wdata);
    chk("acc_wdata", res, acc_wdata);
    chk("carry_we", 8'(!wrap), 8'(carry_we));
    if (!wrap) begin
      chk("carry_out", 8'(d[0]), 8'(carry_out));
    end
    @(negedge clk);
    chk("busy_end", 8'h00, 8'(busy));
    chk("qphase_end", 8'h00, 8'(qphase));
    chk("strobes_end", 8'h00, {6'h00, reg_we, acc_we});
  endtask
  task automatic test_carry();
    exec(opc_rotate_carry, dest_accumulator, 8'h00, 8'he6, 1'b0);
    exec(opc_rotate_carry, dest_register, 8'hff, 8'he6, 1'b1);
    exec(opc_rotate_carry, dest_accumulator, 8'h5a, 8'h01, 1'b1);
  endtask
  task automatic test_wrap();
    exec(opc_rotate_wrap, dest_register, 8'h80, 8'hd7, 1'b0);
    exec(opc_rotate_wrap, dest_accumulator, 8'h01, 8'h01, 1'b1);
  endtask
  // a neighbouring opcode must leave the unit idle
  task automatic test_ignore();
    insn_valid = 1'b1;
    insn = {7'h0d, 1'b1, 8'h33};
    repeat (4) begin
      @(negedge clk);
      chk("busy_other", 8'h00, 8'(busy));
      chk("reg_re_other", 8'h00, 8'(reg_re));
      chk("reg_addr_other", 8'h01, reg_addr);
      chk("qphase_other", 8'h00, 8'(qphase));
    end
    insn_valid = 1'b0;
  endtask
  // a reset in mid-instruction aborts it and leaves the unit ready at once
  task automatic test_reset_mid();
    @(negedge clk);
    insn_valid = 1'b1;
    insn = {opc_rotate_carry, dest_register, 8'h42};
    @(negedge clk);
    insn_valid = 1'b0;
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    chk("busy_rst", 8'h00, 8'(busy));
    chk("qphase_mid_rst", 8'h00, 8'(qphase));
    chk("reg_addr_rst", 8'h00, reg_addr);
    chk("strobes_rst", 8'h00, {5'h00, reg_re, reg_we, acc_we});
    chk("carry_we_rst", 8'h00, 8'(carry_we));
    resetn = 1'b1;
    exec(opc_rotate_carry, dest_register, 8'h42, 8'h81, 1'b0);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    chk("qphase_rst", 8'h00, 8'(qphase));
    resetn = 1'b1;
    test_carry();
    test_wrap();
    test_ignore();
    test_reset_mid();
    finish_test();
  end
endmodule
`default_nettype wire
